// ---- hdl/rsc_pkg.sv ----
package rsc_pkg;

  // register byte offsets
  localparam logic [7:0] RSC_OFF_PM    = 8'h00; // power_mode_select
  localparam logic [7:0] RSC_OFF_RSTA  = 8'h04; // reset_request_reg_a
  localparam logic [7:0] RSC_OFF_RSTB  = 8'h08; // reset_request_reg_b
  localparam logic [7:0] RSC_OFF_STAT  = 8'h0c; // status

  // power mode field
  localparam int         RSC_PM_W        = 3;
  localparam logic [2:0] RSC_PM_ACTIVE   = 3'h0;
  localparam logic [2:0] RSC_PM_BACKUP   = 3'h4;
  localparam logic [2:0] RSC_PM_SHUTDOWN = 3'h7;
  localparam logic [2:0] RSC_PM_RST      = 3'h0;

  // reset_request_reg_a bit positions
  localparam int RSC_BIT_PERIPH = 0;
  localparam int RSC_BIT_SOFT   = 1;
  localparam int RSC_BIT_SYS    = 2;

  // status bit positions
  localparam int RSC_ST_SHUT    = 0;
  localparam int RSC_ST_LOWPWR  = 1;

  localparam logic [31:0] RSC_RSTA_RST = 32'h0000_0000;
  localparam logic [31:0] RSC_RSTB_RST = 32'h0000_0000;

  // axi response codes
  localparam logic [1:0] RSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;

  // one-cycle reset strobes toward the rest of the chip
  typedef struct packed {
    logic periph;    // all peripherals
    logic gpio;      // gpio back to por state
    logic global_control_regs;       // global control regs, clock config
    logic cpu;       // cpu core, restart at reset vector
    logic wdt;       // watchdog_timers
  } rsc_scope_t;

  typedef enum logic [1:0] {
    RSC_RUN,
    RSC_LOWPWR,
    RSC_SHUT
  } rsc_state_t;

  typedef struct packed {
    rsc_state_t  st;
    logic [2:0]  pm;
    logic [31:0] rstb;
    rsc_scope_t  scope;
    logic [31:0] periph_rst;
    logic        power_gate;
    logic        ram_power_off;
    logic        wake_disable;
    logic        restore_active;
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rsc_state_reg_t;

endpackage : rsc_pkg

// ---- hdl/rsc_top.sv ----
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rsc_top (
  // clock and power-on reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // reset and wake sources
  input  wire logic                external_reset_pin_n,
  input  wire logic                wdt_reset_evt,
  input  wire logic                lowpower_wake,
  input  wire logic                deep_sleep_wake,
  // axi4-lite write address
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // axi4-lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // axi4-lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // reset and power controls
  output rsc_pkg::rsc_scope_t      scope_rst,
  output logic [31:0]              periph_rst,
  output logic                     power_gate,
  output logic                     ram_power_off,
  output logic                     wake_disable,
  output logic                     restore_active,
  output logic [2:0]               power_mode_select
);

  rsc_pkg::rsc_state_reg_t s_reg;
  rsc_pkg::rsc_state_reg_t s_next;

  // pin and watchdog come from other domains: two flops first
  logic [1:0] pin_sync_reg;
  logic [1:0] wdt_sync_reg;
  logic [1:0] lpw_sync_reg;
  logic [1:0] dsw_sync_reg;
  logic       pin_prev_reg;
  logic       wdt_prev_reg;
  logic       lpw_prev_reg;
  logic       dsw_prev_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync_reg <= 2'h3;
      wdt_sync_reg <= 2'h0;
      lpw_sync_reg <= 2'h0;
      dsw_sync_reg <= 2'h0;
      pin_prev_reg <= 1'b1;
      wdt_prev_reg <= 1'b0;
      lpw_prev_reg <= 1'b0;
      dsw_prev_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], external_reset_pin_n};
      wdt_sync_reg <= {wdt_sync_reg[0], wdt_reset_evt};
      lpw_sync_reg <= {lpw_sync_reg[0], lowpower_wake};
      dsw_sync_reg <= {dsw_sync_reg[0], deep_sleep_wake};
      pin_prev_reg <= pin_sync_reg[1];
      wdt_prev_reg <= wdt_sync_reg[1];
      lpw_prev_reg <= lpw_sync_reg[1];
      dsw_prev_reg <= dsw_sync_reg[1];
    end
  end

  logic pin_fall;
  logic wdt_rise;
  logic lpw_rise;
  logic dsw_rise;
  assign pin_fall = pin_prev_reg & ~pin_sync_reg[1];
  assign wdt_rise = ~wdt_prev_reg & wdt_sync_reg[1];
  assign lpw_rise = ~lpw_prev_reg & lpw_sync_reg[1];
  assign dsw_rise = ~dsw_prev_reg & dsw_sync_reg[1];

  // merge a 32-bit write under byte strobes
  function automatic logic [31:0] rsc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : rsc_merge

  logic        do_write;
  logic [31:0] wr_a;
  logic [31:0] wr_pm;
  logic        sw_periph;
  logic        sw_soft;
  logic        sw_sys;
  logic        sys_evt;
  logic        soft_evt;
  logic        periph_evt;

  always_comb begin
    s_next = s_reg;
    wr_a = rsc_merge(32'h0000_0000, s_reg.w_data, s_reg.w_strb);
    wr_pm = rsc_merge({29'h0, s_reg.pm}, s_reg.w_data, s_reg.w_strb);
    do_write = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
    sw_periph = do_write & (s_reg.aw_addr == rsc_pkg::RSC_OFF_RSTA)
                & wr_a[rsc_pkg::RSC_BIT_PERIPH];
    sw_soft = do_write & (s_reg.aw_addr == rsc_pkg::RSC_OFF_RSTA)
              & wr_a[rsc_pkg::RSC_BIT_SOFT];
    sw_sys = do_write & (s_reg.aw_addr == rsc_pkg::RSC_OFF_RSTA)
             & wr_a[rsc_pkg::RSC_BIT_SYS];
    // system reset sources; backup exit also counts
    sys_evt = pin_fall | wdt_rise | sw_sys
              | ((s_reg.st == rsc_pkg::RSC_LOWPWR) & lpw_rise);
    soft_evt = sys_evt | sw_soft;
    periph_evt = soft_evt | sw_periph;

    // strobes last one cycle: the reset completes immediately
    s_next.scope = '0;
    s_next.periph_rst = '0;
    s_next.restore_active = 1'b0;

    // axi write channel capture, either order
    if (s_axi_awvalid & s_reg.awready) begin
      s_next.awready = 1'b0;
      s_next.aw_got = 1'b1;
      s_next.aw_addr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid & s_reg.wready) begin
      s_next.wready = 1'b0;
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid & s_axi_bready) begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end
    // reset_request_reg_b pulses every set bit together for one cycle; a new write below wins
    if (s_reg.rstb != 32'h0000_0000) begin
      s_next.periph_rst = s_reg.rstb;
      s_next.rstb = 32'h0000_0000;
    end
    if (do_write) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = rsc_pkg::RSC_RESP_OKAY;
      unique case (s_reg.aw_addr)
        rsc_pkg::RSC_OFF_PM: begin
          s_next.pm = wr_pm[2:0];
        end
        rsc_pkg::RSC_OFF_RSTA: begin
          // request bits self-clear; nothing is stored
        end
        rsc_pkg::RSC_OFF_RSTB: begin
          s_next.rstb = rsc_merge(32'h0000_0000, s_reg.w_data, s_reg.w_strb);
        end
        rsc_pkg::RSC_OFF_STAT: begin
        end
        default: s_next.bresp = rsc_pkg::RSC_RESP_SLVERR;
      endcase
    end
    // axi read channel
    if (s_reg.rvalid & s_axi_rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    if (s_axi_arvalid & s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = rsc_pkg::RSC_RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        rsc_pkg::RSC_OFF_PM:   s_next.rdata = {29'h0, s_reg.pm};
        rsc_pkg::RSC_OFF_RSTA: s_next.rdata = rsc_pkg::RSC_RSTA_RST;
        rsc_pkg::RSC_OFF_RSTB: s_next.rdata = s_reg.rstb;
        rsc_pkg::RSC_OFF_STAT: begin
          s_next.rdata = 32'h0;
          s_next.rdata[rsc_pkg::RSC_ST_SHUT] = s_reg.st == rsc_pkg::RSC_SHUT;
          s_next.rdata[rsc_pkg::RSC_ST_LOWPWR] = s_reg.st == rsc_pkg::RSC_LOWPWR;
        end
        default: begin
          s_next.rdata = 32'h0;
          s_next.rresp = rsc_pkg::RSC_RESP_SLVERR;
        end
      endcase
    end

    unique case (s_reg.st)
      rsc_pkg::RSC_RUN: begin
        if (dsw_rise) begin
          s_next.restore_active = 1'b1;
        end
        if (do_write & (s_reg.aw_addr == rsc_pkg::RSC_OFF_PM)
            & (wr_pm[2:0] == rsc_pkg::RSC_PM_SHUTDOWN)) begin
          s_next.st = rsc_pkg::RSC_SHUT;
          s_next.power_gate = 1'b1;
          s_next.ram_power_off = 1'b1;
          s_next.wake_disable = 1'b1;
        end else if (do_write & (s_reg.aw_addr == rsc_pkg::RSC_OFF_PM)
                     & (wr_pm[2:0] == rsc_pkg::RSC_PM_BACKUP)) begin
          s_next.st = rsc_pkg::RSC_LOWPWR;
        end else if (periph_evt) begin
          s_next.scope.periph = 1'b1;
          s_next.periph_rst = '1;
          s_next.scope.gpio = soft_evt;
          s_next.scope.global_control_regs = sys_evt;
          s_next.scope.cpu = sys_evt;
          s_next.scope.wdt = sys_evt;
          // global regs incl. mode fall back to active; aod untouched
          if (sys_evt) begin
            s_next.pm = rsc_pkg::RSC_PM_ACTIVE;
          end
        end
      end
      rsc_pkg::RSC_LOWPWR: begin
        if (sys_evt) begin
          s_next.st = rsc_pkg::RSC_RUN;
          s_next.pm = rsc_pkg::RSC_PM_ACTIVE;
          s_next.scope = '1;
          s_next.periph_rst = '1;
        end
      end
      rsc_pkg::RSC_SHUT: begin
        // only aresetn (power-on) leaves this state
        s_next.st = rsc_pkg::RSC_SHUT;
        s_next.pm = rsc_pkg::RSC_PM_SHUTDOWN;
      end
      // unused fourth code falls back to run
      default: s_next.st = rsc_pkg::RSC_RUN;
    endcase
  end

  // power-on reset returns everything to default
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.st <= rsc_pkg::RSC_RUN;
      s_reg.pm <= rsc_pkg::RSC_PM_RST;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign scope_rst = s_reg.scope;
  assign periph_rst = s_reg.periph_rst;
  assign power_gate = s_reg.power_gate;
  assign ram_power_off = s_reg.ram_power_off;
  assign wake_disable = s_reg.wake_disable;
  assign restore_active = s_reg.restore_active;
  assign power_mode_select = s_reg.pm;

  // write to the mode field in this cycle
  function automatic logic do_write_pm();
    return do_write && s_reg.aw_addr == rsc_pkg::RSC_OFF_PM;
  endfunction : do_write_pm

  // shutdown holds all gates until power-on reset
  shut_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == rsc_pkg::RSC_SHUT) |=> (s_reg.st == rsc_pkg::RSC_SHUT) && power_gate)
    else $error("shutdown left without power-on reset");
  shut_enter_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && s_reg.st == rsc_pkg::RSC_RUN && s_reg.aw_addr == rsc_pkg::RSC_OFF_PM
     && wr_pm[2:0] == rsc_pkg::RSC_PM_SHUTDOWN) |=> (s_reg.st == rsc_pkg::RSC_SHUT))
    else $error("mode 7 did not enter shutdown");
  shut_gates_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == rsc_pkg::RSC_SHUT) |-> power_gate && ram_power_off && wake_disable)
    else $error("shutdown without all gates");
  ram_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ram_power_off) |-> (s_reg.st == rsc_pkg::RSC_SHUT))
    else $error("ram powered off outside shutdown");
  wake_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(wake_disable) |-> $rose(power_gate))
    else $error("wake disable not tied to shutdown entry");
  soft_gpio_a: assert property (@(posedge aclk) disable iff (!aresetn)
    scope_rst.gpio |-> scope_rst.periph && (periph_rst == 32'hffff_ffff))
    else $error("soft reset without peripheral reset");
  periph_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sw_periph && !soft_evt && s_reg.st == rsc_pkg::RSC_RUN && !do_write_pm())
    |=> scope_rst.periph && !scope_rst.gpio && !scope_rst.cpu && !scope_rst.wdt)
    else $error("peripheral reset touched spared blocks");
  sys_scope_a: assert property (@(posedge aclk) disable iff (!aresetn)
    scope_rst.cpu |-> scope_rst.global_control_regs && scope_rst.wdt && scope_rst.gpio ##1 !scope_rst.cpu)
    else $error("system reset scope wrong");
  req_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.rstb != 32'h0) |=> (s_reg.rstb == 32'h0))
    else $error("request bits did not clear");

  // every reset scope includes all peripherals
  periph_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
    scope_rst.periph |-> (periph_rst == 32'hffff_ffff))
    else $error("peripheral reset did not cover every peripheral");
  sys_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    scope_rst.global_control_regs |-> (power_mode_select == rsc_pkg::RSC_PM_ACTIVE))
    else $error("system reset left the mode field set");
  shut_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == rsc_pkg::RSC_SHUT) |-> (power_mode_select == rsc_pkg::RSC_PM_SHUTDOWN))
    else $error("shutdown state without mode 7");
  rest_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    restore_active |-> ($past(s_reg.st) == rsc_pkg::RSC_RUN))
    else $error("restore pulse outside active mode");

endmodule : rsc_top
`default_nettype wire

// ---- test/reset_and_shutdown_control_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module reset_and_shutdown_control_test;
  logic                aclk          = 1'h0;
  logic                aresetn       = 1'h0;
  wire logic           external_reset_pin_n, wdt_reset_evt, lowpower_wake, deep_sleep_wake;
  logic [7:0]          s_axi_awaddr  = 8'h00;
  logic [7:0]          s_axi_araddr  = 8'h00;
  logic [31:0]         s_axi_wdata   = 32'h0;
  logic [3:0]          s_axi_wstrb   = 4'hf;
  logic                s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic                s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [31:0]         s_axi_rdata, periph_rst, seen_prst;
  rsc_pkg::rsc_scope_t scope_rst, seen_scope;
  logic                power_gate, ram_power_off, wake_disable, restore_active, seen_rest;
  logic [2:0]          power_mode_select;
  logic                seen_clr      = 1'h1;
  int                  err_count = 0, checks_done = 0;
  localparam logic [1:0] OK = rsc_pkg::RSC_RESP_OKAY;

  rsc_top dut (.aclk, .aresetn, .external_reset_pin_n, .wdt_reset_evt, .lowpower_wake,
    .deep_sleep_wake, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scope_rst, .periph_rst, .power_gate, .ram_power_off,
    .wake_disable, .restore_active, .power_mode_select);

  rsc_src_model src (.aclk, .external_reset_pin_n, .wdt_reset_evt, .lowpower_wake,
    .deep_sleep_wake);

  always #4 aclk = ~aclk;

  // sticky record of one-cycle strobes, so a pulse is never missed
  // one driver only: clearing goes through seen_clr
  always @(posedge aclk) begin
    if (seen_clr) begin
      seen_scope <= 5'h00;
      seen_prst  <= 32'h0;
      seen_rest  <= 1'h0;
    end else begin
      seen_scope <= seen_scope | scope_rst;
      seen_prst  <= seen_prst | periph_rst;
      seen_rest  <= seen_rest | restore_active;
    end
  end

  task automatic complete_run;
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // a bus answer that never comes ends the run
  task automatic lost;
    err_count++;
    complete_run();
  endtask : lost

  // records are cleared at the next rising edge, then collect again
  task automatic clear_seen;
    seen_clr <= 1'h1;
    @(posedge aclk);
    seen_clr <= 1'h0;
  endtask : clear_seen

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) lost();
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int i;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) lost();
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rd

  // software reset request: scope strobes, all peripherals, bit reads back 0
  task automatic sw_reset(input logic [31:0] bits, input logic [4:0] exp);
    clear_seen();
    wr(rsc_pkg::RSC_OFF_RSTA, bits, OK);
    repeat (2) @(posedge aclk);
    chk({27'h0, seen_scope}, {27'h0, exp});
    chk(seen_prst, 32'hffff_ffff);
    rd(rsc_pkg::RSC_OFF_RSTA, 32'h0, OK);
  endtask : sw_reset

  // pin, watchdog or backup wake: full system reset, mode back to active
  task automatic src_reset(input int which);
    clear_seen();
    src.strobe(which);
    repeat (6) @(posedge aclk);
    chk({27'h0, seen_scope}, 32'h1f);
    chk(seen_prst, 32'hffff_ffff);
    chk({29'h0, power_mode_select}, 32'h0);
    chk({31'h0, power_gate}, 32'h0);
  endtask : src_reset

  task automatic shutdown_case;
    wr(rsc_pkg::RSC_OFF_PM, 32'h7, OK);
    chk({29'h0, power_gate, ram_power_off, wake_disable}, 32'h7);
    rd(rsc_pkg::RSC_OFF_STAT, 32'h1, OK);
    clear_seen();
    src.strobe(0);
    src.strobe(1);
    src.strobe(2);
    src.strobe(3);
    repeat (4) @(posedge aclk);
    chk({26'h0, seen_rest, seen_scope}, 32'h0);
    wr(rsc_pkg::RSC_OFF_PM, 32'h0, OK);
    chk({29'h0, power_mode_select}, 32'h7);
    chk({31'h0, power_gate}, 32'h1);
    // only a power-on reset brings the device back
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk({29'h0, power_gate, ram_power_off, wake_disable}, 32'h0);
    rd(rsc_pkg::RSC_OFF_PM, 32'h0, OK);
  endtask : shutdown_case

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(rsc_pkg::RSC_OFF_PM, 32'h0, OK);
    rd(rsc_pkg::RSC_OFF_RSTB, 32'h0, OK);
    rd(8'h10, 32'h0, rsc_pkg::RSC_RESP_SLVERR);
    wr(8'h10, 32'h1, rsc_pkg::RSC_RESP_SLVERR);
    sw_reset(32'h1, 5'h10);
    sw_reset(32'h2, 5'h18);
    wr(rsc_pkg::RSC_OFF_PM, 32'h1, OK);
    sw_reset(32'h4, 5'h1f);
    chk({29'h0, power_mode_select}, 32'h0);
    // no byte lane enabled: mode 7 must not land, so no shutdown
    s_axi_wstrb <= 4'h0;
    wr(rsc_pkg::RSC_OFF_PM, 32'h7, OK);
    s_axi_wstrb <= 4'hf;
    rd(rsc_pkg::RSC_OFF_STAT, 32'h0, OK);
    // single peripheral through the second request register
    clear_seen();
    wr(rsc_pkg::RSC_OFF_RSTB, 32'h20, OK);
    repeat (2) @(posedge aclk);
    chk(seen_prst, 32'h20);
    chk({27'h0, seen_scope}, 32'h0);
    src_reset(0);
    src_reset(1);
    wr(rsc_pkg::RSC_OFF_PM, 32'h4, OK);
    rd(rsc_pkg::RSC_OFF_STAT, 32'h2, OK);
    src_reset(2);
    clear_seen();
    src.strobe(3);
    repeat (4) @(posedge aclk);
    chk({31'h0, seen_rest}, 32'h1);
    chk({27'h0, seen_scope}, 32'h0);
    shutdown_case();
    complete_run();
  end
endmodule : reset_and_shutdown_control_test
`default_nettype wire

// ---- test/rsc_src_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// far side of the block: reset pin, watchdog and the two wake lines
module rsc_src_model (
  // clock
  input  wire logic aclk,
  // source lines
  output logic      external_reset_pin_n,
  output logic      wdt_reset_evt,
  output logic      lowpower_wake,
  output logic      deep_sleep_wake
);
  // idle levels: pin released high, events low
  initial begin
    external_reset_pin_n = 1'h1;
    wdt_reset_evt        = 1'h0;
    lowpower_wake        = 1'h0;
    deep_sleep_wake      = 1'h0;
  end

  // hold one source for four edges so the two-flop sync cannot miss it
  task automatic strobe(input int which);
    @(posedge aclk);
    case (which)
      0: external_reset_pin_n <= 1'h0;
      1: wdt_reset_evt <= 1'h1;
      2: lowpower_wake <= 1'h1;
      default: deep_sleep_wake <= 1'h1;
    endcase
    repeat (4) @(posedge aclk);
    external_reset_pin_n <= 1'h1;
    wdt_reset_evt        <= 1'h0;
    lowpower_wake        <= 1'h0;
    deep_sleep_wake      <= 1'h0;
    @(posedge aclk);
  endtask : strobe
endmodule : rsc_src_model
`default_nettype wire
